// [core/eccrl_top.sv]
// ecc check, correct, log and report logic with apb registers
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module eccrl_top
  import eccrl_pkg::*;
(
  // apb
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // incoming data toward the processor
  input  wire eccrl_pkg::eccrl_word_s      in_word,
  output logic      [eccrl_pkg::DATA_W-1:0] out_data,
  output logic                             out_valid,
  output logic                             out_ue,
  // interconnect pass-through path
  input  wire eccrl_pkg::eccrl_word_s      xbar_in,
  output eccrl_pkg::eccrl_word_s           xbar_out,
  output logic                             rstop,
  // scan port for history and record-stop
  input  wire eccrl_pkg::eccrl_scan_s      scan,
  output logic      [eccrl_pkg::DATA_W-1:0] scan_data,
  output logic                             scan_rstop,
  // reports
  output logic                             irq,
  output logic                             io_irq_valid,
  output logic      [5:0]                  io_irq_target
);
  import eccrl_pkg::*;

  // --------------------------------------------------------------------------
  // secded decoder: hamming positions 1..71 plus overall parity
  // --------------------------------------------------------------------------
  // the check code is generated by the source; memory only stores it
  function automatic logic [7:0] calc_syn(input logic [DATA_W-1:0] d,
                                          input logic [CHK_W-1:0] c);
    logic [6:0] s;
    logic       p;
    int         pos;
    int         k;
    s   = c[6:0];
    p   = ^{d, c};
    pos = 1;
    k   = 0;
    for (int i = 1; i < 72; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        if (k < DATA_W)
        begin
          s = s ^ (d[k] ? i[6:0] : 7'h00);
        end
        k = k + 1;
      end
    end
    pos = pos;
    return {p, s};
  endfunction : calc_syn

  // data bit index of a hamming position, or 255 when a check position
  function automatic logic [7:0] pos_to_bit(input logic [6:0] s);
    logic [7:0] r;
    int         k;
    r = 8'hff;
    k = 0;
    for (int i = 1; i < 72; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        if (i[6:0] == s)
        begin
          r = k[7:0];
        end
        k = k + 1;
      end
    end
    return r;
  endfunction : pos_to_bit

  // --------------------------------------------------------------------------
  // decode of processor-bound data
  // --------------------------------------------------------------------------
  logic [7:0]        syn;
  logic              is_ce;
  logic              is_ue;
  logic              chk_on;
  logic [DATA_W-1:0] fix_data;
  logic [7:0]        fbit;

  // all three sources are checked alike
  always_comb
  begin
    chk_on   = in_word.valid && (in_word.src != ECCRL_SRC_NONE);
    syn      = calc_syn(in_word.data, in_word.chk);
    is_ce    = chk_on && syn[7];
    is_ue    = chk_on && !syn[7] && (syn[6:0] != 7'h00);
    fbit     = pos_to_bit(syn[6:0]);
    fix_data = in_word.data;
    if (is_ce && fbit != 8'hff)
    begin
      fix_data[fbit[5:0]] = ~in_word.data[fbit[5:0]];
    end
  end

  logic [DATA_W-1:0] out_data_q, out_data_d;
  logic              out_valid_q, out_valid_d;
  logic              out_ue_q, out_ue_d;

  // uncorrectable words go out untouched, flagged
  always_comb
  begin
    out_valid_d = in_word.valid;
    out_data_d  = is_ue ? in_word.data : fix_data;
    out_ue_d    = is_ue;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_data_q  <= '0;
      out_valid_q <= 1'b0;
      out_ue_q    <= 1'b0;
    end
    else
    begin
      out_data_q  <= out_data_d;
      out_valid_q <= out_valid_d;
      out_ue_q    <= out_ue_d;
    end
  end

  assign out_data  = out_data_q;
  assign out_valid = out_valid_q;
  assign out_ue    = out_ue_q;

  // --------------------------------------------------------------------------
  // interconnect path: check only, forward as is, record stop
  // --------------------------------------------------------------------------
  logic [7:0]         xsyn;
  logic               x_err;
  eccrl_word_s        xbar_q;
  logic               rstop_q, rstop_d;
  logic [HIST_AW-1:0] hptr_q, hptr_d;
  logic               rstop_clr;

  always_comb
  begin
    xsyn    = calc_syn(xbar_in.data, xbar_in.chk);
    x_err   = xbar_in.valid && (xsyn != 8'h00);
    rstop_d = rstop_q;
    if (rstop_clr)
    begin
      rstop_d = 1'b0;
    end
    if (x_err)
    begin
      rstop_d = 1'b1;
    end
    // history stops advancing once frozen
    hptr_d = (xbar_in.valid && !rstop_q) ? hptr_q + 1'b1 : hptr_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xbar_q  <= '0;
      rstop_q <= 1'b0;
      hptr_q  <= '0;
    end
    else
    begin
      xbar_q  <= xbar_in;
      rstop_q <= rstop_d;
      hptr_q  <= hptr_d;
    end
  end

  assign xbar_out   = xbar_q;
  assign rstop      = rstop_q;
  assign scan_rstop = rstop_q;

  // the erroring word itself is recorded, then the buffer freezes
  eccrl_hist_mem #(
    .W  (DATA_W),
    .AW (HIST_AW)
  ) u_hist (
    .pclk  (pclk),
    .we    (xbar_in.valid && !rstop_q),
    .waddr (hptr_q),
    .wdata (xbar_in.data),
    .raddr (scan.idx),
    .rdata (scan_data)
  );

  // --------------------------------------------------------------------------
  // fault logs and status
  // --------------------------------------------------------------------------
  logic [31:0]       ctrl_q, ctrl_d;
  logic [ST_W-1:0]   stat_q, stat_d, en_q, en_d, ev;
  logic [ADDR_W-1:0] afar_q, afar_d, io_ce_q, io_ce_d, io_ue_q, io_ue_d;
  logic [1:0]        afsr_q, afsr_d;
  logic [8:0]        dberr_q, dberr_d;
  logic [5:0]        map_q, map_d;
  logic              io_fault;
  logic              wr;
  logic [ST_W-1:0]   clr;

  assign wr        = psel && penable && pwrite;
  assign clr       = (wr && paddr == OFS_INT_CLR) ? pwdata[ST_W-1:0] : '0;
  assign rstop_clr = wr && paddr == OFS_RSTOP && pwdata[0];
  assign io_fault  = (is_ce || is_ue) && in_word.src == ECCRL_SRC_IO;

  always_comb
  begin
    ev              = '0;
    ev[ST_CE]       = is_ce && !ctrl_q[CTRL_IGNCE] && ctrl_q[CTRL_CEEN];
    ev[ST_UE]       = is_ue;
    ev[ST_IO_CE]    = is_ce && in_word.src == ECCRL_SRC_IO;
    ev[ST_IO_UE]    = is_ue && in_word.src == ECCRL_SRC_IO;
    ev[ST_RSTOP]    = x_err;
    // set wins over a clear in the same cycle
    stat_d  = (stat_q & ~clr) | ev;
    ctrl_d  = (wr && paddr == OFS_CTRL) ? pwdata : ctrl_q;
    en_d    = (wr && paddr == OFS_INT_EN) ? pwdata[ST_W-1:0] : en_q;
    map_d   = (wr && paddr == OFS_IO_MAP) ? pwdata[5:0] : map_q;
    afar_d  = afar_q;
    afsr_d  = afsr_q;
    dberr_d = dberr_q;
    io_ce_d = io_ce_q;
    io_ue_d = io_ue_q;
    // an uncorrectable log is held until cleared or replaced by a later uncorrectable; a correctable one may not overwrite it
    if (wr && paddr == OFS_AFSR && pwdata[0])
    begin
      afsr_d = FT_NONE;
    end
    if (is_ue || (is_ce && afsr_q != FT_UE))
    begin
      afar_d  = in_word.addr;
      afsr_d  = is_ue ? FT_UE : FT_CE;
      dberr_d = {is_ue, syn};
    end
    if (is_ce && in_word.src == ECCRL_SRC_IO)
    begin
      io_ce_d = in_word.addr;
    end
    if (is_ue && in_word.src == ECCRL_SRC_IO)
    begin
      io_ue_d = in_word.addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= CTRL_RST;
      stat_q  <= '0;
      en_q    <= '0;
      map_q   <= '0;
      afar_q  <= '0;
      afsr_q  <= FT_NONE;
      dberr_q <= '0;
      io_ce_q <= '0;
      io_ue_q <= '0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      stat_q  <= stat_d;
      en_q    <= en_d;
      map_q   <= map_d;
      afar_q  <= afar_d;
      afsr_q  <= afsr_d;
      dberr_q <= dberr_d;
      io_ce_q <= io_ce_d;
      io_ue_q <= io_ue_d;
    end
  end

  // level interrupt; ignored correctables never set the bit
  assign irq           = |(stat_q & en_q);
  assign io_irq_target = map_q;

  logic io_irq_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_irq_q <= 1'b0;
    end
    else
    begin
      io_irq_q <= io_fault;
    end
  end
  assign io_irq_valid = io_irq_q;

  // --------------------------------------------------------------------------
  // apb read mux; zero-wait, unmapped reads zero with pslverr
  // --------------------------------------------------------------------------
  logic [31:0] rd;
  logic        hit;
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      OFS_CTRL:    rd = ctrl_q;
      OFS_STAT:    rd = {27'h0, stat_q};
      OFS_INT_EN:  rd = {27'h0, en_q};
      OFS_INT_CLR: rd = 32'h0;
      OFS_AFAR:    rd = afar_q;
      OFS_AFSR:    rd = {30'h0, afsr_q};
      OFS_DBERR:   rd = {23'h0, dberr_q};
      OFS_IO_CE_A: rd = io_ce_q;
      OFS_IO_UE_A: rd = io_ue_q;
      OFS_IO_MAP:  rd = {26'h0, map_q};
      OFS_RSTOP:   rd = {31'h0, rstop_q};
      default:
      begin
        rd  = 32'h0;
        hit = 1'b0;
      end
    endcase
  end
  assign prdata  = rd;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_ue_out;
    @(posedge pclk) disable iff (!presetn) is_ue |=> out_ue && out_valid;
  endproperty
  a_ue_out: assert property (p_ue_out) else $error("ue not flagged");

  property p_ue_data;
    @(posedge pclk) disable iff (!presetn)
      is_ue |=> out_data == $past(in_word.data);
  endproperty
  a_ue_data: assert property (p_ue_data) else $error("ue data altered");

  property p_log;
    @(posedge pclk) disable iff (!presetn)
      is_ue |=> afar_q == $past(in_word.addr) && afsr_q == FT_UE;
  endproperty
  a_log: assert property (p_log) else $error("fault not logged");

  property p_dberr;
    @(posedge pclk) disable iff (!presetn) is_ce && afsr_q != FT_UE |=> !dberr_q[8];
  endproperty
  a_dberr: assert property (p_dberr) else $error("dberr class wrong");

  property p_ign;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[CTRL_IGNCE] && is_ce |=> !stat_q[ST_CE] || $past(stat_q[ST_CE]);
  endproperty
  a_ign: assert property (p_ign) else $error("ignored ce raised");

  property p_ceen;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[CTRL_CEEN] && !ctrl_q[CTRL_IGNCE] && is_ce |=> stat_q[ST_CE];
  endproperty
  a_ceen: assert property (p_ceen) else $error("ce fault missing");

  property p_rstop;
    @(posedge pclk) disable iff (!presetn)
      x_err && !rstop_q |=> rstop && hptr_q == $past(hptr_q) + 1'b1;
  endproperty
  a_rstop: assert property (p_rstop) else $error("record stop missing");

  property p_fwd;
    @(posedge pclk) disable iff (!presetn) xbar_in.valid |=> xbar_out == $past(xbar_in);
  endproperty
  a_fwd: assert property (p_fwd) else $error("xbar data changed");

  property p_ioirq;
    @(posedge pclk) disable iff (!presetn) io_fault |=> io_irq_valid ##0 io_irq_target == map_q;
  endproperty
  a_ioirq: assert property (p_ioirq) else $error("io irq missing");

  c_ce:   cover property (@(posedge pclk) disable iff (!presetn) is_ce ##1 out_valid);
  c_ue:   cover property (@(posedge pclk) disable iff (!presetn) is_ue ##1 irq);
  c_rs:   cover property (@(posedge pclk) disable iff (!presetn) x_err ##1 rstop);
  c_io:   cover property (@(posedge pclk) disable iff (!presetn) io_fault ##1 io_irq_valid);
endmodule : eccrl_top

// [core/eccrl_pkg.sv]
// package of constants and types for the ecc error report logic
// ----------------------------------------------------------------------------
// Summary of operation
// - correctable single-bit data errors are fixed before delivery to the processor
// - every detected error is reported; fault address and fault type are captured
// - buffer error register holds correctable/uncorrectable flag and syndrome
// - ignore mode: correctable errors still logged but set no ce status bit; io correctables still set their io status bit and the io interrupt
// - correctable enable bit set and ignore mode off: each correctable error raises a fault
// - checking covers memory, io and processor-interrupt data sources
// - interconnect error freezes history buffer and sets record-stop bit
// - history and record-stop bits readable through a scan port
// - io bridge logs correctable and uncorrectable classes separately
// - io bridge fault interrupts the processor named by its mapping register
// - interconnect forwards correctable data unmodified
// - memory stores check bits only, no checking or correction
// ----------------------------------------------------------------------------
package eccrl_pkg;

  localparam int DATA_W = 64;
  localparam int CHK_W  = 8;
  localparam int ADDR_W = 32;
  localparam int HIST_D = 16;
  localparam int HIST_AW = 4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STAT    = 8'h04;
  localparam logic [7:0] OFS_INT_EN  = 8'h08;
  localparam logic [7:0] OFS_INT_CLR = 8'h0c;
  localparam logic [7:0] OFS_AFAR    = 8'h10;
  localparam logic [7:0] OFS_AFSR    = 8'h14;
  localparam logic [7:0] OFS_DBERR   = 8'h18;
  localparam logic [7:0] OFS_IO_CE_A = 8'h1c;
  localparam logic [7:0] OFS_IO_UE_A = 8'h20;
  localparam logic [7:0] OFS_IO_MAP  = 8'h24;
  localparam logic [7:0] OFS_RSTOP   = 8'h28;

  // control fields
  localparam int CTRL_CEEN  = 0;
  localparam int CTRL_IGNCE = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // status / enable / clear layout
  localparam int ST_CE    = 0;
  localparam int ST_UE    = 1;
  localparam int ST_IO_CE = 2;
  localparam int ST_IO_UE = 3;
  localparam int ST_RSTOP = 4;
  localparam int ST_W     = 5;

  // fault type codes
  localparam logic [1:0] FT_NONE = 2'h0;
  localparam logic [1:0] FT_CE   = 2'h1;
  localparam logic [1:0] FT_UE   = 2'h2;

  // data source of a transfer
  typedef enum logic [1:0] {
    ECCRL_SRC_MEM  = 2'b00,
    ECCRL_SRC_IO   = 2'b01,
    ECCRL_SRC_PINT = 2'b10,
    ECCRL_SRC_NONE = 2'b11
  } eccrl_src_e;

  // incoming codeword
  typedef struct packed {
    logic              valid;
    eccrl_src_e        src;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CHK_W-1:0]  chk;
  } eccrl_word_s;

  // scan port
  typedef struct packed {
    logic               rd;
    logic [HIST_AW-1:0] idx;
  } eccrl_scan_s;

endpackage : eccrl_pkg

// [core/eccrl_hist_mem.sv]
// history buffer memory with registered read port
`timescale 1ns/1ps
module eccrl_hist_mem #(
  parameter int W  = 64,
  parameter int AW = 4
) (
  // clock
  input  wire logic          pclk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem_q [2**AW];

  // storage has no reset; contents meaningful only after writes
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule : eccrl_hist_mem

// [testbench/eccrl_cpu_model.sv]
// processor-side model that collects delivered words and io interrupts
`timescale 1ns/1ps
module eccrl_cpu_model
  import eccrl_pkg::*;
(
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // delivered data
  input  wire logic [eccrl_pkg::DATA_W-1:0] out_data,
  input  wire logic                         out_valid,
  input  wire logic                         out_ue,
  // io bridge interrupt
  input  wire logic                         io_irq_valid,
  input  wire logic [5:0]                   io_irq_target,
  // captured view for the bench
  output logic      [eccrl_pkg::DATA_W-1:0] got_data,
  output logic                              got_ue,
  output int                                n_words,
  output int                                n_io_irq,
  output logic      [5:0]                   got_target
);
  // ----
  // capture
  // ----
  // every cycle with valid high counts, so a stuck valid shows up as extra words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      got_data   <= '0;
      got_ue     <= 1'b0;
      n_words    <= 0;
      n_io_irq   <= 0;
      got_target <= '0;
    end
    else
    begin
      if (out_valid)
      begin
        got_data <= out_data;
        got_ue   <= out_ue;
        n_words  <= n_words + 1;
      end
      if (io_irq_valid)
      begin
        n_io_irq   <= n_io_irq + 1;
        got_target <= io_irq_target;
      end
    end
  end
endmodule : eccrl_cpu_model

// [testbench/tb_top.sv]
// self-checking bench for the ecc error report logic
`timescale 1ns/1ps
`define CHK(a, b) \
  begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import eccrl_pkg::*;
  // ----
  // signals
  // ----
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, errv, out_valid, out_ue, rstop, scan_rstop;
  logic        irq, io_irq_valid, cpu_ue, hit;
  logic [5:0]  io_irq_target, cpu_tgt, map;
  logic [63:0] out_data, scan_data, cpu_data, xd, d, fl;
  logic [63:0] snap [16];
  logic [63:0] snap_a [16];
  logic [31:0] a;
  eccrl_word_s in_word = '0;
  eccrl_word_s xbar_in = '0;
  eccrl_word_s xbar_out;
  eccrl_scan_s scan = '0;
  int          n_fail, comparisons, cpu_n, n_io, k, b;

  always #12.5 pclk = ~pclk;

  eccrl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_word(in_word), .out_data(out_data), .out_valid(out_valid),
    .out_ue(out_ue), .xbar_in(xbar_in), .xbar_out(xbar_out), .rstop(rstop), .scan(scan),
    .scan_data(scan_data), .scan_rstop(scan_rstop), .irq(irq),
    .io_irq_valid(io_irq_valid), .io_irq_target(io_irq_target));

  eccrl_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .out_data(out_data),
    .out_valid(out_valid), .out_ue(out_ue), .io_irq_valid(io_irq_valid),
    .io_irq_target(io_irq_target), .got_data(cpu_data), .got_ue(cpu_ue),
    .n_words(cpu_n), .n_io_irq(n_io), .got_target(cpu_tgt));

  // ----
  // expectation helpers
  // ----
  // codeword position of data bit i, powers of two hold check bits
  function automatic logic [6:0] pos_of(input int i);
    int n;
    n = 0;
    pos_of = '0;
    for (int p = 3; p < 72; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (n == i)
          pos_of = p[6:0];
        n++;
      end
    end
  endfunction : pos_of

  function automatic logic [7:0] enc(input logic [63:0] v);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < 64; i++)
      if (v[i])
        c[6:0] = c[6:0] ^ pos_of(i);
    c[7] = ^{v, c[6:0]};
    return c;
  endfunction : enc

  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ----
  // drivers
  // ----
  // bounded wait on pready; data taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      end_of_test();
    end
    #1;
  endtask : apb

  task automatic send(input int s, input logic [31:0] ad, input logic [63:0] v,
                      input logic [63:0] f);
    eccrl_word_s w;
    w.valid = 1'b1;
    w.src   = eccrl_src_e'(s);
    w.addr  = ad;
    w.chk   = enc(v);
    w.data  = v ^ f;
    @(posedge pclk);
    in_word <= w;
    @(posedge pclk);
    in_word.valid <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask : send

  task automatic xsend(input logic [63:0] f);
    eccrl_word_s w;
    w.valid = 1'b1;
    w.src   = ECCRL_SRC_MEM;
    w.addr  = $urandom;
    w.data  = {$urandom, $urandom};
    w.chk   = enc(w.data);
    w.data  = w.data ^ f;
    xd = w.data;
    @(posedge pclk);
    xbar_in <= w;
    @(posedge pclk);
    xbar_in.valid <= 1'b0;
    #1;
    `CHK(xbar_out, w)
  endtask : xsend

  task automatic scan_all();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      scan <= '{rd: 1'b1, idx: 4'(i)};
      @(posedge pclk);
      #1;
      snap[i] = scan_data;
    end
    scan.rd <= 1'b0;
  endtask : scan_all

  // ----
  // main sequence
  // ----
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    void'($urandom(32'h26cc5bad));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, 0);
    `CHK(rdv, CTRL_RST)
    apb(1, OFS_STAT, 32'h1f);
    apb(0, OFS_STAT, 0);
    `CHK(rdv[4:0], 5'h00)
    apb(0, 8'h40, 0);
    `CHK({errv, rdv}, {1'b1, 32'h0})
    map = 6'($urandom_range(63));
    apb(1, OFS_IO_MAP, {26'h0, map});
    apb(1, OFS_INT_EN, 32'h1f);
    // clean traffic from every checked source
    k = cpu_n;
    for (int i = 0; i < 20; i++)
    begin
      d = {$urandom, $urandom};
      send($urandom_range(2), $urandom, d, 64'h0);
      `CHK({cpu_ue, cpu_data}, {1'b0, d})
    end
    `CHK(cpu_n, k + 20)
    apb(0, OFS_STAT, 0);
    `CHK({irq, rdv[4:0]}, 6'h00)
    // single-bit error from each source, interrupt enabled
    for (int s = 0; s < 3; s++)
    begin
      a = $urandom;
      d = {$urandom, $urandom};
      b = $urandom_range(63);
      k = n_io;
      send(s, a, d, 64'h1 << b);
      `CHK({cpu_ue, cpu_data}, {1'b0, d})
      `CHK(irq, 1'b1)
      apb(0, OFS_AFAR, 0);
      `CHK(rdv, a)
      apb(0, OFS_AFSR, 0);
      `CHK(rdv[1:0], FT_CE)
      apb(0, OFS_DBERR, 0);
      `CHK({rdv[8], rdv[6:0]}, {1'b0, pos_of(b)})
      if (s == 1)
      begin
        apb(0, OFS_IO_CE_A, 0);
        `CHK(rdv, a)
        `CHK({n_io, cpu_tgt}, {k + 1, map})
      end
      apb(1, OFS_AFSR, 1);
    end
    // masking and clearing of the level interrupt
    apb(1, OFS_INT_EN, 0);
    `CHK(irq, 1'b0)
    apb(1, OFS_INT_EN, 32'h1f);
    `CHK(irq, 1'b1)
    apb(1, OFS_INT_CLR, 32'h1f);
    apb(0, OFS_STAT, 0);
    `CHK({irq, rdv[4:0]}, 6'h00)
    // ignore mode still logs but stays quiet
    apb(1, OFS_CTRL, 3);
    a = $urandom;
    send(0, a, {$urandom, $urandom}, 64'h1 << $urandom_range(63));
    `CHK(irq, 1'b0)
    apb(0, OFS_AFAR, 0);
    `CHK(rdv, a)
    apb(0, OFS_AFSR, 0);
    `CHK(rdv[1:0], FT_CE)
    apb(1, OFS_CTRL, 1);
    apb(1, OFS_AFSR, 1);
    apb(1, OFS_INT_CLR, 32'h1f);
    // double-bit error on an io read, then a later single-bit error
    a = $urandom;
    d = {$urandom, $urandom};
    b = $urandom_range(62);
    fl = (64'h1 << b) | (64'h1 << (b + 1));
    k = n_io;
    send(1, a, d, fl);
    `CHK({cpu_ue, cpu_data}, {1'b1, d ^ fl})
    apb(0, OFS_DBERR, 0);
    `CHK(rdv[8], 1'b1)
    apb(0, OFS_IO_UE_A, 0);
    `CHK(rdv, a)
    apb(0, OFS_STAT, 0);
    `CHK({rdv[ST_IO_UE], rdv[ST_UE]}, 2'b11)
    `CHK({n_io, cpu_tgt}, {k + 1, map})
    send(0, ~a, d, 64'h1);
    apb(0, OFS_AFAR, 0);
    `CHK(rdv, a)
    apb(0, OFS_AFSR, 0);
    `CHK(rdv[1:0], FT_UE)
    apb(1, OFS_AFSR, 1);
    apb(0, OFS_AFSR, 0);
    `CHK(rdv[1:0], FT_NONE)
    // interconnect: record stop, freeze and scan readout
    apb(1, OFS_RSTOP, 1);
    repeat (5) xsend(64'h0);
    `CHK(rstop, 1'b0)
    xsend(64'h1 << $urandom_range(63));
    `CHK({rstop, scan_rstop}, 2'b11)
    apb(0, OFS_STAT, 0);
    `CHK(rdv[ST_RSTOP], 1'b1)
    scan_all();
    snap_a = snap;
    hit = 1'b0;
    for (int i = 0; i < 16; i++)
      if (snap[i] === xd)
        hit = 1'b1;
    `CHK(hit, 1'b1)
    repeat (5) xsend(64'h0);
    scan_all();
    for (int i = 0; i < 16; i++)
      `CHK(snap[i], snap_a[i])
    apb(1, OFS_RSTOP, 1);
    `CHK(rstop, 1'b0)
    end_of_test();
  end
endmodule : tb_top
